// ### dv/eeprom_pump_model.sv
// charge pump and cell timing model for the program/erase controller
// assumes pump_on is the applied high voltage and apply_pulse is synced
`timescale 1ns/10ps
module eeprom_pump_model #(
	parameter int HOLD = 16 // shortened program hold time, bus cycles
) (
	input  wire logic ref_clk,     // bus clock
	input  wire logic rst,         // async reset, high
	input  wire logic pump_on,     // high voltage applied
	output logic      apply_pulse  // hold time elapsed strobe
);
	int cnt_q;
	// time the hold from each rise of the voltage; a drop restarts it
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			cnt_q <= 0;
			apply_pulse <= 1'b0;
		end else if (!pump_on) begin
			cnt_q <= 0;
			apply_pulse <= 1'b0;
		end else if (cnt_q < HOLD + 4) begin
			cnt_q <= cnt_q + 1;
			apply_pulse <= (cnt_q >= HOLD);
		end else begin
			apply_pulse <= 1'b0;
		end
	end
endmodule

// ### dv/test_eeprom_program_erase_ctrl.sv
// self-checking bench for the program/erase controller
// assumes the pump model beside it
`timescale 1ns/10ps
module test_eeprom_program_erase_ctrl;
	import eeprom_ctrl_pkg::*;
	// ----------------------------------------
	// signals
	// ----------------------------------------
	logic        ref_clk = 1'b0;
	logic        rst = 1'b1;
	logic [15:0] address = 16'h0000;
	logic        read = 1'b0;
	logic        write = 1'b0;
	logic [31:0] writedata = 32'h0;
	logic [31:0] readdata;
	logic        waitrequest;
	logic        stop_mode = 1'b0;
	logic        apply_pulse;
	logic        pump_on;
	logic        pump_clk_bus;
	logic        array_off;
	logic [31:0] exp_q[$];
	logic [31:0] seed = 32'h7B0F;
	logic [15:0] a;
	int          miscompares = 0;
	int          n_compared = 0;
	always #50 ref_clk = ~ref_clk;
	eeprom_program_erase_ctrl u_dut (.ref_clk(ref_clk), .rst(rst), .address(address),
		.read(read), .write(write), .writedata(writedata), .readdata(readdata),
		.waitrequest(waitrequest), .stop_mode(stop_mode), .apply_pulse(apply_pulse),
		.pump_on(pump_on), .pump_clk_bus(pump_clk_bus), .array_off(array_off));
	eeprom_pump_model u_pump (.ref_clk(ref_clk), .rst(rst), .pump_on(pump_on),
		.apply_pulse(apply_pulse));
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		n_compared++;
		if (e !== s) begin
			$display("ERROR %s expected %h seen %h", nm, e, s);
			miscompares++;
		end
	endtask
	task automatic complete_run();
		$display("compared %0d mismatches %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	// one avalon transfer, held until waitrequest is seen low
	task automatic bus(input logic w, input logic [15:0] ad, input logic [7:0] d);
		@(posedge ref_clk);
		address <= ad;
		writedata <= {24'h0, d};
		read <= !w;
		write <= w;
		do begin
			@(posedge ref_clk);
		end while (waitrequest !== 1'b0);
		read <= 1'b0;
		write <= 1'b0;
	endtask
	task automatic rd(input logic [15:0] ad, input logic [7:0] e);
		exp_q.push_back({24'h0, e});
		bus(1'b0, ad, 8'h00);
	endtask
	// latch, pump, stop dip, hold, then the two-step release
	task automatic op(input logic [1:0] m, input logic [15:0] ad, input logic [7:0] d,
		input logic on);
		bus(1'b1, PECTRL_ADDR, {4'h0, m, 2'h2});
		bus(1'b1, ad ^ 16'h0002, ~d);
		bus(1'b1, ad, d);
		bus(1'b1, PECTRL_ADDR, {4'h0, m, 2'h3});
		repeat (3) @(posedge ref_clk);
		chk("pump_on", {31'h0, on}, {31'h0, pump_on});
		if (on) begin
			bus(1'b1, PECTRL_ADDR, {4'h0, ~m, 2'h3});
			rd(PECTRL_ADDR, {4'h0, m, 2'h3});
			stop_mode <= 1'b1;
			repeat (6) @(posedge ref_clk);
			chk("pump_stop", 32'h0, {31'h0, pump_on});
			stop_mode <= 1'b0;
			repeat (6) @(posedge ref_clk);
			chk("pump_back", 32'h1, {31'h0, pump_on});
			while (apply_pulse !== 1'b1) @(posedge ref_clk);
			while (apply_pulse !== 1'b0) @(posedge ref_clk);
			repeat (4) @(posedge ref_clk);
		end
		bus(1'b1, PECTRL_ADDR, 8'h00);
		if (on) rd(PECTRL_ADDR, {4'h0, m, 2'h2});
		bus(1'b1, PECTRL_ADDR, 8'h00);
	endtask
	// ----------------------------------------
	// read data scoreboard and watchdog
	// ----------------------------------------
	always @(posedge ref_clk) begin
		if (read === 1'b1 && waitrequest === 1'b0) chk("readdata", exp_q.pop_front(), readdata);
	end
	initial begin
		repeat (30000) @(posedge ref_clk);
		miscompares++;
		complete_run();
	end
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	initial begin
		repeat (4) @(posedge ref_clk);
		rst <= 1'b0;
		repeat (2) @(posedge ref_clk);
		rd(PECTRL_ADDR, PECTRL_RESET);
		rd(SHADOW_ADDR, NVCFG_ERASED);
		rd(ARRAY_BASE, ERASED_BYTE);
		rd(16'h1234, 8'h00);
		op(OP_PROGRAM, 16'h0810, 8'h5A, 1'b0);
		op(OP_PROGRAM, NVCFG_ADDR, 8'hF0, 1'b1);
		rd(NVCFG_ADDR, 8'hF0);
		bus(1'b1, 16'h1234, 8'h55);
		bus(1'b1, PECTRL_ADDR, 8'h01);
		rd(PECTRL_ADDR, 8'h00);
		bus(1'b1, PECTRL_ADDR, 8'h02);
		bus(1'b1, PECTRL_ADDR, 8'h06);
		rd(PECTRL_ADDR, 8'h02);
		bus(1'b1, 16'h0820, 8'h3C);
		rd(16'h0830, 8'h3C);
		bus(1'b1, PECTRL_ADDR, 8'h00);
		rd(16'h0820, 8'hFF);
		op(OP_PROGRAM, 16'h0810, 8'h5A, 1'b1);
		rd(16'h0810, 8'h5A);
		rd(16'h0812, 8'hFF);
		for (int i = 0; i < 3; i++) begin
			seed = xs(seed);
			a = ARRAY_BASE + {7'h0, seed[8:0]};
			op(OP_BYTE_ERASE, a, seed[31:24], 1'b1);
			op(OP_PROGRAM, a, seed[23:16], 1'b1);
			rd(a, seed[23:16]);
		end
		op(OP_BLOCK_ERASE, a ^ 16'h0011, 8'h00, 1'b1);
		rd(a, 8'hFF);
		op(OP_BULK_ERASE, 16'h0990, 8'h00, 1'b1);
		rd(16'h0810, 8'hFF);
		rd(NVCFG_ADDR, 8'hF0);
		op(OP_PROGRAM, 16'h0810, 8'h5A, 1'b1);
		bus(1'b1, PECTRL_ADDR, 8'h30);
		rd(16'h0810, 8'hFF);
		chk("clk_off", 32'h3, {30'h0, pump_clk_bus, array_off});
		bus(1'b1, PECTRL_ADDR, 8'h00);
		op(OP_BYTE_ERASE, NVCFG_ADDR, 8'h00, 1'b1);
		op(OP_PROGRAM, NVCFG_ADDR, 8'hF1, 1'b1);
		rd(SHADOW_ADDR, 8'hF0);
		rd(NVCFG_ADDR, 8'hF1);
		rd(SHADOW_ADDR, 8'hF1);
		op(OP_BULK_ERASE, 16'h0990, 8'h00, 1'b0);
		op(OP_PROGRAM, 16'h087F, 8'h00, 1'b0);
		op(OP_PROGRAM, 16'h0880, 8'h00, 1'b1);
		rd(16'h0810, 8'h5A);
		op(OP_PROGRAM, NVCFG_ADDR, 8'hE1, 1'b1);
		rd(NVCFG_ADDR, 8'hE1);
		op(OP_BYTE_ERASE, 16'h08F5, 8'h00, 1'b0);
		rd(PECTRL_ADDR, 8'h06);
		op(OP_BYTE_ERASE, 16'h08E0, 8'h00, 1'b1);
		op(OP_BLOCK_ERASE, 16'h0900, 8'h00, 1'b0);
		op(OP_BYTE_ERASE, NVCFG_ADDR, 8'h00, 1'b0);
		rd(NVCFG_ADDR, 8'hE1);
		complete_run();
	end
endmodule

// ### rtl/eeprom_ctrl_pkg.sv
// constants for the eeprom program/erase controller
// assumes a 16-bit byte address space seen through an avalon-mm word slave
//
// How it works
// - protected blocks never erase unless block erase latches the config byte; bulk then ignored
// - latch captures only valid array or config byte writes
// - block or bulk erase, config byte untouched
// - latched data returned on array reads
// - control writes wait for latched array write
// - high voltage refused without prior sequence
// - erase mode frozen while high voltage on
// - pump on only when enabled and latched
// - combined clear drops only high voltage
// - four protection blocks of 128 bytes
// - protect bits map to 0x0800 upward ranges
// - protected target gets no program voltage
// - shadow reloads on reset and config read
// - security armed blocks 0x08F0 to 0x08FF
// - armed security disables block, bulk, config
// - armed security only cleared by reset
// - pump clock select, bus or rc oscillator
// - power down makes array reads return erased
// - erase select bits encode the operation
// - stop removes voltage, exit restores it
// - erase gives ones, program clears bits
package eeprom_ctrl_pkg;
	// ----------------------------------------
	// address map
	// ----------------------------------------
	localparam logic [15:0] ARRAY_BASE      = 16'h0800;
	localparam logic [15:0] ARRAY_LAST      = 16'h09FF;
	localparam logic [15:0] SECURE_FIRST    = 16'h08F0;
	localparam logic [15:0] SECURE_LAST     = 16'h08FF;
	localparam logic [15:0] NVCFG_ADDR      = 16'hFE1C;
	localparam logic [15:0] PECTRL_ADDR     = 16'hFE1B;
	localparam logic [15:0] SHADOW_ADDR     = 16'hFE1D;
	localparam int          ARRAY_BYTES     = 512;
	localparam int          BLOCK_BYTES     = 128;
	// ----------------------------------------
	// control register fields
	// ----------------------------------------
	localparam int          F_PGM           = 0;
	localparam int          F_LAT           = 1;
	localparam int          F_RAS_LO        = 2;
	localparam int          F_RAS_HI        = 3;
	localparam int          F_OFF           = 4;
	localparam int          F_BCLK          = 5;
	localparam logic [7:0]  PECTRL_RESET    = 8'h00;
	localparam logic [7:0]  ERASED_BYTE     = 8'hFF;
	localparam logic [7:0]  NVCFG_ERASED    = 8'hFF;
	localparam int          F_SEC           = 4;
	// ----------------------------------------
	// operation codes
	// ----------------------------------------
	localparam logic [1:0]  OP_PROGRAM      = 2'h0;
	localparam logic [1:0]  OP_BYTE_ERASE   = 2'h1;
	localparam logic [1:0]  OP_BLOCK_ERASE  = 2'h2;
	localparam logic [1:0]  OP_BULK_ERASE   = 2'h3;
endpackage

// ### rtl/eeprom_program_erase_ctrl.sv
// eeprom program/erase controller with cell array in flip-flops
// assumes an avalon-mm master; address is a byte address, data in low byte
//
// Register access over Avalon-MM was chosen for this implementation.
`timescale 1ns/10ps
module eeprom_program_erase_ctrl #(
	parameter int DEPTH = eeprom_ctrl_pkg::ARRAY_BYTES // array size in bytes
) (
	input  wire logic        ref_clk,       // 10 mhz bus clock
	input  wire logic        rst,           // async reset, high
	input  wire logic [15:0] address,       // byte address
	input  wire logic        read,          // read request
	input  wire logic        write,         // write request
	input  wire logic [31:0] writedata,     // write data, low byte used
	output logic      [31:0] readdata,      // read data
	output logic             waitrequest,   // stall
	input  wire logic        stop_mode,     // device in stop mode, pin
	input  wire logic        apply_pulse,   // pump cycle strobe: commit array op
	output logic             pump_on,       // charge pump running
	output logic             pump_clk_bus,  // pump clocked from bus clock
	output logic             array_off      // array powered down
);
	import eeprom_ctrl_pkg::*;

	// ----------------------------------------
	// state
	// ----------------------------------------
	logic [7:0]  mem_q [DEPTH];
	logic [7:0]  nv_q;
	logic [7:0]  shadow_q;
	logic        shadow_init_q;
	logic        pgm_q, lat_q, off_q, bclk_q;
	logic [1:0]  ras_q;
	logic        latched_q;
	logic        foreign_q;
	logic [15:0] laddr_q;
	logic [7:0]  ldata_q;
	logic        stop_s1_q, stop_q;
	logic        pulse_s1_q, pulse_q, pulse_old_q;
	logic        hv_q;

	// ----------------------------------------
	// decode
	// ----------------------------------------
	function automatic logic in_range(input logic [15:0] a, input logic [15:0] lo,
	                                  input logic [15:0] hi);
		in_range = (a >= lo) && (a <= hi);
	endfunction

	wire         req        = (read || write) && !waitrequest; // taken in the answer cycle
	wire         hit_array  = in_range(address, ARRAY_BASE, ARRAY_LAST);
	wire         hit_nv     = address == NVCFG_ADDR;
	wire         hit_ctrl   = address == PECTRL_ADDR;
	wire         hit_shadow = address == SHADOW_ADDR;
	wire         armed      = !shadow_q[F_SEC];
	wire         sec_hit    = in_range(address, SECURE_FIRST, SECURE_LAST);
	// a secured byte or an armed config byte is not a valid latched write
	wire         valid_wr   = write && req && (hit_array || hit_nv)
	                          && !(armed && (sec_hit || hit_nv));
	wire [7:0]   wd         = writedata[7:0];
	wire [8:0]   idx        = 9'(address - ARRAY_BASE);
	wire [8:0]   lidx       = 9'(laddr_q - ARRAY_BASE);
	wire [1:0]   lblk       = lidx[8:7];
	wire         lnv        = laddr_q == NVCFG_ADDR;
	wire         lsec       = in_range(laddr_q, SECURE_FIRST, SECURE_LAST);
	wire         ctrl_wr    = write && req && hit_ctrl;
	// control writes frozen while latched but nothing captured yet
	wire         ctrl_ok    = !lat_q || latched_q;
	wire         new_pgm    = wd[F_PGM];
	wire         new_lat    = wd[F_LAT];
	// voltage refused unless latch enable is set and a write was captured
	wire         pgm_allow  = !(!lat_q && foreign_q) && lat_q && latched_q;
	wire         prot_any   = |shadow_q[3:0];
	wire         prot_tgt   = lnv ? 1'b0 : shadow_q[lblk];
	// protected target or bulk with any protection means no operation
	wire         op_block   = prot_tgt || (ras_q == OP_BULK_ERASE && prot_any)
	                          || (armed && (ras_q[1] || lsec || lnv));
	// voltage only with both enables, a latched write and not in stop
	wire         hv_d       = pgm_q && lat_q && latched_q && !stop_q && !op_block;
	wire         commit     = hv_q && hv_d && pulse_q && !pulse_old_q;

	// ----------------------------------------
	// synchronisers, pulse edge and voltage state
	// ----------------------------------------
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			stop_s1_q   <= 1'b0;
			stop_q      <= 1'b0;
			pulse_s1_q  <= 1'b0;
			pulse_q     <= 1'b0;
			pulse_old_q <= 1'b0;
			hv_q        <= 1'b0;
		end else begin
			stop_s1_q   <= stop_mode;
			stop_q      <= stop_s1_q;
			pulse_s1_q  <= apply_pulse;
			pulse_q     <= pulse_s1_q;
			pulse_old_q <= pulse_q;
			hv_q        <= hv_d;
		end
	end

	// ----------------------------------------
	// control register
	// ----------------------------------------
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			pgm_q  <= PECTRL_RESET[F_PGM];
			lat_q  <= PECTRL_RESET[F_LAT];
			ras_q  <= PECTRL_RESET[F_RAS_HI:F_RAS_LO];
			off_q  <= PECTRL_RESET[F_OFF];
			bclk_q <= PECTRL_RESET[F_BCLK];
		end else if (ctrl_wr && ctrl_ok) begin
			off_q  <= wd[F_OFF];
			bclk_q <= wd[F_BCLK];
			if (!pgm_q) begin
				ras_q <= wd[F_RAS_HI:F_RAS_LO];
			end
			pgm_q <= new_pgm && (pgm_q || pgm_allow);
			// latch enable stays while high voltage is (or was) on
			lat_q <= pgm_q ? 1'b1 : new_lat;
		end
	end

	// ----------------------------------------
	// address/data latch and sequence tracking
	// ----------------------------------------
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			latched_q <= 1'b0;
			foreign_q <= 1'b0;
			laddr_q   <= 16'h0000;
			ldata_q   <= 8'h00;
		end else begin
			if (lat_q && valid_wr && !pgm_q) begin
				latched_q <= 1'b1;
				laddr_q   <= address;
				ldata_q   <= wd;
			end else if (!lat_q) begin
				latched_q <= 1'b0;
			end
			if (write && req && !hit_array && !hit_nv && !hit_ctrl) begin
				foreign_q <= 1'b1;
			end else if (valid_wr || (ctrl_wr && new_lat)) begin
				foreign_q <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// cell array and configuration byte
	// ----------------------------------------
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem_q[i] <= ERASED_BYTE;
			end
			nv_q <= NVCFG_ERASED;
		end else if (commit) begin
			unique case (ras_q)
				OP_PROGRAM: begin
					if (lnv) nv_q <= nv_q & ldata_q;
					else mem_q[lidx] <= mem_q[lidx] & ldata_q;
				end
				OP_BYTE_ERASE: begin
					if (lnv) nv_q <= ERASED_BYTE;
					else mem_q[lidx] <= ERASED_BYTE;
				end
				OP_BLOCK_ERASE: begin
					for (int i = 0; i < DEPTH; i++) begin
						if (9'(i) >> 7 == 9'(lblk)) mem_q[i] <= ERASED_BYTE;
					end
				end
				OP_BULK_ERASE: begin
					for (int i = 0; i < DEPTH; i++) begin
						mem_q[i] <= ERASED_BYTE;
					end
				end
			endcase
		end
	end

	// ----------------------------------------
	// shadow load at reset release and on config read
	// ----------------------------------------
	wire nv_rd = read && req && hit_nv;
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			shadow_q      <= NVCFG_ERASED;
			shadow_init_q <= 1'b0;
		end else if (!shadow_init_q || nv_rd) begin
			shadow_init_q <= 1'b1;
			// once armed the shadow is frozen
			if (!(armed && shadow_init_q)) begin
				shadow_q <= nv_q;
			end
		end
	end

	// ----------------------------------------
	// read data and outputs
	// ----------------------------------------
	wire [7:0] arr_rd = lat_q ? ldata_q : mem_q[idx];
	wire [7:0] rd_mux = hit_array ? (off_q ? ERASED_BYTE : arr_rd) :
	                    hit_nv     ? (lat_q && lnv ? ldata_q : nv_q) :
	                    hit_ctrl   ? {2'h0, bclk_q, off_q, ras_q, lat_q, pgm_q} :
	                    hit_shadow ? shadow_q : 8'h00;
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			readdata     <= 32'h0000_0000;
			waitrequest  <= 1'b1;
			pump_on      <= 1'b0;
			pump_clk_bus <= 1'b0;
			array_off    <= 1'b0;
		end else begin
			readdata     <= {24'h000000, rd_mux};
			waitrequest  <= !((read || write) && waitrequest);
			pump_on      <= hv_d;
			pump_clk_bus <= bclk_q;
			array_off    <= off_q;
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	property p_pump_needs_latch;
		@(posedge ref_clk) disable iff (rst) pump_on |-> (lat_q && latched_q);
	endproperty
	a_pump_needs_latch: assert property (p_pump_needs_latch) else $error("pump without latch");

	property p_stop_kills_pump;
		@(posedge ref_clk) disable iff (rst) stop_q |=> !pump_on;
	endproperty
	a_stop_kills_pump: assert property (p_stop_kills_pump) else $error("pump on in stop");

	property p_lat_holds;
		@(posedge ref_clk) disable iff (rst) pgm_q |=> lat_q;
	endproperty
	a_lat_holds: assert property (p_lat_holds) else $error("latch dropped under hv");

	property p_mode_frozen;
		@(posedge ref_clk) disable iff (rst) pgm_q && $past(pgm_q) |-> $stable(ras_q);
	endproperty
	a_mode_frozen: assert property (p_mode_frozen) else $error("mode changed under hv");

	property p_protect_no_hv;
		@(posedge ref_clk) disable iff (rst) op_block |=> !hv_q;
	endproperty
	a_protect_no_hv: assert property (p_protect_no_hv) else $error("hv on protected");

	property p_armed_stays;
		@(posedge ref_clk) disable iff (rst) (armed && shadow_init_q) |=> armed;
	endproperty
	a_armed_stays: assert property (p_armed_stays) else $error("security disarmed");

	property p_ctrl_blocked;
		@(posedge ref_clk) disable iff (rst)
			(ctrl_wr && lat_q && !latched_q) |=> $stable(off_q) && $stable(bclk_q);
	endproperty
	a_ctrl_blocked: assert property (p_ctrl_blocked) else $error("ctrl accepted early");

	property p_latched_read;
		@(posedge ref_clk) disable iff (rst)
			(read && req && hit_array && lat_q && !off_q) |=> readdata[7:0] == $past(ldata_q);
	endproperty
	a_latched_read: assert property (p_latched_read) else $error("latched read wrong");

	// ----------------------------------------
	// sequences for the multi-step checks
	// ----------------------------------------
	// request answered after exactly one stall cycle
	sequence s_one_wait;
		!waitrequest ##1 waitrequest;
	endsequence

	// control write asking to drop both enables at once
	sequence s_clear_both;
		ctrl_wr && ctrl_ok && pgm_q && !new_pgm && !new_lat;
	endsequence

	// only the voltage enable has gone
	sequence s_only_hv_dropped;
		!pgm_q && lat_q;
	endsequence

	// stop left while a permitted operation is still enabled
	sequence s_stop_left;
		$fell(stop_q) && pgm_q && lat_q && latched_q && !op_block;
	endsequence

	// ----------------------------------------
	// more checks
	// ----------------------------------------
	// bus answer one cycle after a stalled request
	property p_one_wait;
		@(posedge ref_clk) disable iff (rst) (read || write) && waitrequest |=> s_one_wait;
	endproperty
	a_one_wait: assert property (p_one_wait) else $error("bus wait state wrong");

	// combined clear leaves latch enable set
	property p_combined_clear;
		@(posedge ref_clk) disable iff (rst) s_clear_both |=> s_only_hv_dropped;
	endproperty
	a_combined_clear: assert property (p_combined_clear) else $error("both enables dropped");

	// voltage returns once stop is left
	property p_stop_restores;
		@(posedge ref_clk) disable iff (rst) s_stop_left |=> pump_on;
	endproperty
	a_stop_restores: assert property (p_stop_restores) else $error("pump not restored");

	// stop keeps the voltage enable bit
	property p_stop_keeps_enable;
		@(posedge ref_clk) disable iff (rst) stop_q && pgm_q && !ctrl_wr |=> pgm_q;
	endproperty
	a_stop_keeps_enable: assert property (p_stop_keeps_enable) else $error("enable lost in stop");

	// voltage enable refused out of sequence
	property p_hv_refused;
		@(posedge ref_clk) disable iff (rst)
			ctrl_wr && new_pgm && !pgm_q && !pgm_allow |=> !pgm_q;
	endproperty
	a_hv_refused: assert property (p_hv_refused) else $error("voltage enable accepted");

	// clearing the enable stops the pump
	property p_drop_stops_pump;
		@(posedge ref_clk) disable iff (rst) $fell(pgm_q) |=> !pump_on;
	endproperty
	a_drop_stops_pump: assert property (p_drop_stops_pump) else $error("pump left running");

	// a valid array write is captured
	property p_capture;
		@(posedge ref_clk) disable iff (rst) lat_q && valid_wr && !pgm_q |=>
			latched_q && laddr_q == $past(address) && ldata_q == $past(wd);
	endproperty
	a_capture: assert property (p_capture) else $error("write not captured");

	// nothing stays captured without latch enable
	property p_no_capture;
		@(posedge ref_clk) disable iff (rst) !lat_q |=> !latched_q;
	endproperty
	a_no_capture: assert property (p_no_capture) else $error("capture without latch");

	// secured writes leave the latch alone
	property p_secure_not_latched;
		@(posedge ref_clk) disable iff (rst)
			write && req && armed && sec_hit |=> $stable(laddr_q) && $stable(ldata_q);
	endproperty
	a_secure_not_latched: assert property (p_secure_not_latched) else $error("secured write latched");

	// no voltage on a secured or config target once armed
	property p_secure_no_hv;
		@(posedge ref_clk) disable iff (rst) armed && (lsec || lnv) |=> !hv_q;
	endproperty
	a_secure_no_hv: assert property (p_secure_no_hv) else $error("hv on secured target");

	// powered-down array reads as erased
	property p_off_reads_erased;
		@(posedge ref_clk) disable iff (rst)
			read && req && hit_array && off_q |=> readdata[7:0] == ERASED_BYTE;
	endproperty
	a_off_reads_erased: assert property (p_off_reads_erased) else $error("read while off");

	// config read reloads the shadow
	property p_shadow_reload;
		@(posedge ref_clk) disable iff (rst) nv_rd && !armed |=> shadow_q == $past(nv_q);
	endproperty
	a_shadow_reload: assert property (p_shadow_reload) else $error("shadow not reloaded");

	// armed shadow never changes
	property p_shadow_frozen;
		@(posedge ref_clk) disable iff (rst) armed && shadow_init_q |=> $stable(shadow_q);
	endproperty
	a_shadow_frozen: assert property (p_shadow_frozen) else $error("armed shadow changed");

	// block and bulk erase leave the config byte
	property p_nv_untouched;
		@(posedge ref_clk) disable iff (rst) commit && ras_q[1] |=> $stable(nv_q);
	endproperty
	a_nv_untouched: assert property (p_nv_untouched) else $error("config byte erased");

	// programming only clears bits
	property p_program_clears;
		@(posedge ref_clk) disable iff (rst)
			commit && ras_q == OP_PROGRAM && !lnv |=> (mem_q[lidx] & ~ldata_q) == 8'h00;
	endproperty
	a_program_clears: assert property (p_program_clears) else $error("program set a bit");
endmodule
